// File: rtl/vfc_regs.svh
`ifndef VFC_REGS_SVH
`define VFC_REGS_SVH

// register byte offsets
`define VFC_OFS_LOCK      8'h00
`define VFC_OFS_MAXF      8'h04
`define VFC_OFS_MIDF      8'h08
`define VFC_OFS_MINF      8'h0C
`define VFC_OFS_TOPV      8'h10
`define VFC_OFS_MIDV      8'h14
`define VFC_OFS_BOOSTV    8'h18
`define VFC_OFS_FLOOR     8'h1C
`define VFC_OFS_DRIVE     8'h20
`define VFC_OFS_RESTORE   8'h24
`define VFC_OFS_TIME0     8'h28
`define VFC_OFS_TIME7     8'h44
`define VFC_OFS_ESTOP     8'h48
`define VFC_OFS_SETF      8'h4C
`define VFC_OFS_REFF      8'h50
`define VFC_OFS_OUTF      8'h54
`define VFC_OFS_OUTV      8'h58
`define VFC_OFS_STATE     8'h5C

// frequencies in 0.01 Hz, voltages in 0.1 V, times in 0.1 s
`define VFC_MAXF_MIN      17'h003E8
`define VFC_MAXF_MAX      17'h186A0
`define VFC_MAXF_DEF      17'h01388
`define VFC_MIDF_MIN      17'h0000A
`define VFC_MIDF_DEF      17'h001F4
`define VFC_MINF_MIN      17'h0000A
`define VFC_MINF_MAX      17'h04E20
`define VFC_MINF_DEF      17'h00032
`define VFC_REFF_MIN      17'h0000A
`define VFC_REFF_DEF      17'h01388
`define VFC_FLOOR_DEF     17'h00000
`define VFC_V_MIN         13'h0001
`define VFC_TOPV_380      13'h0ED8
`define VFC_TOPV_220      13'h0898
`define VFC_TOPV_LIM380   13'h13EC
`define VFC_TOPV_LIM220   13'h09F6
`define VFC_MIDV_MAX      13'h13EC
`define VFC_MIDV_DEF      13'h00C8
`define VFC_BOOSTV_MAX    13'h0ED8
`define VFC_BOOSTV_DEF    13'h0064
`define VFC_TIME_MIN      16'h0001
`define VFC_TIME_MAX      16'hFDE8
`define VFC_TIME_DEF      16'h0064
`define VFC_ESTOP_DEF     16'h0000
`define VFC_RESTORE_MAX   8'h0A
`define VFC_RESTORE_GO    8'h08

// ramp time base: one time unit in ms and the clock in kHz
`define VFC_TIME_UNIT_MS  100
`define VFC_CLK_KHZ       50000

`endif

// File: rtl/vfc_pkg.sv
package vfc_pkg;

    // ramp engine states
    typedef enum logic [1:0] {
        VFC_IDLE  = 2'b00,
        VFC_RUN   = 2'b01,
        VFC_ESTOP = 2'b10
    } vfc_ramp_e_t;

    // commands from terminals and keypad
    typedef struct packed {
        logic       run;        // run command level
        logic       jog;        // jog request level
        logic       estop;      // emergency stop terminal level
        logic       multiSeg;   // multi-segment operation active
        logic [1:0] termPair;   // pair chosen by terminals
        logic [1:0] segPair;    // pair chosen by segment table
    } vfc_cmd_t;

    // software settings
    typedef struct packed {
        logic              paramLock;
        logic [16:0]       maxRunFreq;
        logic [16:0]       midCurveFreq;
        logic [16:0]       minCurveFreq;
        logic [16:0]       refFreq;
        logic [12:0]       topVoltage;
        logic [12:0]       midCurveVoltage;
        logic [12:0]       lowFreqBoostVoltage;
        logic [16:0]       freqFloor;
        logic              driveMethodSelect;
        logic [7:0]        restoreDefaultsCode;
        logic [3:0][15:0]  accelTime;
        logic [3:0][15:0]  decelTime;
        logic [15:0]       estopRampTime;
        logic [16:0]       setFreq;
    } vfc_params_t;

    // whole module state
    typedef struct packed {
        vfc_params_t  p;
        vfc_ramp_e_t  mode;
        logic [16:0]  freq;
        logic [12:0]  volt;
        logic [39:0]  acc;
        logic         driveOn;
        logic         waitReq;
        logic [31:0]  rdata;
    } vfc_state_t;

endpackage : vfc_pkg

// File: rtl/vfc_curve_ramp.sv
`timescale 1ns/1ps
`include "vfc_regs.svh"

module vfc_curve_ramp
    import vfc_pkg::*;
#(
    parameter longint TENTH_CYCLES = `VFC_TIME_UNIT_MS * `VFC_CLK_KHZ
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // unit strap: 1 for the 220 V grade
    input  wire logic        grade220,
    // terminal and keypad commands
    input  wire vfc_cmd_t    cmd,
    // avalon-mm slave
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // inverter outputs
    output logic      [16:0] outFreq,
    output logic      [12:0] outVoltage,
    output logic             driveOn
);

    vfc_state_t s_q;          // registered state
    vfc_state_t s_d;          // next state
    logic        req;         // any bus request
    logic        acc;         // request accepted this edge
    logic [5:0]  idx;         // word index of the access
    logic [1:0]  pair;        // active time pair
    logic [15:0] rampTime;    // time for the current slope
    logic [39:0] stepCycles;  // ramp time in clock cycles, accumulator threshold
    logic [39:0] accSum;      // rate accumulator plus increment
    logic [16:0] target;      // clamped ramp target
    logic [16:0] midF;        // mid frequency clamped to reference
    logic [12:0] topLim;      // top voltage ceiling for this grade
    logic [16:0] wf;          // write data as frequency
    logic [12:0] wv;          // write data as voltage
    logic [15:0] wt;          // write data as time

    // factory values, top voltage by grade
    function automatic vfc_params_t defaults(input logic g220);
        vfc_params_t d;
        d.paramLock           = 1'b0;
        d.maxRunFreq          = `VFC_MAXF_DEF;
        d.midCurveFreq        = `VFC_MIDF_DEF;
        d.minCurveFreq        = `VFC_MINF_DEF;
        d.refFreq             = `VFC_REFF_DEF;
        d.topVoltage          = g220 ? `VFC_TOPV_220 : `VFC_TOPV_380;
        d.midCurveVoltage     = `VFC_MIDV_DEF;
        d.lowFreqBoostVoltage = `VFC_BOOSTV_DEF;
        d.freqFloor           = `VFC_FLOOR_DEF;
        d.driveMethodSelect   = 1'b0;
        d.restoreDefaultsCode = 8'h00;
        d.accelTime           = {4{`VFC_TIME_DEF}};
        d.decelTime           = {4{`VFC_TIME_DEF}};
        d.estopRampTime       = `VFC_ESTOP_DEF;
        d.setFreq             = `VFC_MAXF_DEF;
        return d;
    endfunction : defaults

    // straight line between two curve points
    function automatic logic [12:0] interp(
        input logic [16:0] f, input logic [16:0] f0, input logic [16:0] f1,
        input logic [12:0] v0, input logic [12:0] v1);
        logic signed [47:0] num;
        if (f1 <= f0 || f >= f1) begin
            return v1;
        end
        num = (48'(signed'({1'b0, v1})) - 48'(signed'({1'b0, v0})))
              * 48'(signed'({1'b0, f - f0}));
        num = num / 48'(signed'({1'b0, f1 - f0}));
        return 13'(48'(signed'({1'b0, v0})) + num);
    endfunction : interp

    // bus decode helpers, grade voltage ceiling and clamped mid frequency
    assign req   = read | write;
    assign acc   = req & ~s_q.waitReq;
    assign idx   = address[7:2];
    assign wf    = writedata[16:0];
    assign wv    = writedata[12:0];
    assign wt    = writedata[15:0];
    assign topLim = grade220 ? `VFC_TOPV_LIM220 : `VFC_TOPV_LIM380;
    assign midF  = (s_q.p.midCurveFreq > s_q.p.refFreq) ?
                   s_q.p.refFreq : s_q.p.midCurveFreq;

    // pair choice: jog first, then segment table or terminals
    always_comb begin
        if (cmd.jog) begin
            pair = 2'h3;
        end else if (cmd.multiSeg) begin
            pair = cmd.segPair;
        end else begin
            pair = cmd.termPair;
        end
    end

    // ramp target and slope time
    always_comb begin
        // a released run or jog ramps down to zero, floor no longer held
        if (s_q.mode == VFC_RUN && (cmd.run | cmd.jog)) begin
            target = (s_q.p.setFreq < s_q.p.freqFloor) ?
                     s_q.p.freqFloor : s_q.p.setFreq;
            // max applied last so it always wins over the floor
            if (target > s_q.p.maxRunFreq) begin
                target = s_q.p.maxRunFreq;
            end
        end else begin
            target = 17'h00000;
        end
        if (s_q.mode == VFC_ESTOP) begin
            rampTime = s_q.p.estopRampTime;
        end else if (s_q.freq < target) begin
            rampTime = s_q.p.accelTime[pair];
        end else begin
            rampTime = s_q.p.decelTime[pair];
        end
        stepCycles = 40'(64'(rampTime) * 64'(TENTH_CYCLES));
        accSum     = s_q.acc + 40'(s_q.p.maxRunFreq);
    end

    // whole next-state logic
    always_comb begin
        s_d = s_q;
        // bus: one wait cycle, then accept
        s_d.waitReq = ~(req & s_q.waitReq);
        if (req & s_q.waitReq) begin
            case (address)
                `VFC_OFS_LOCK:    s_d.rdata = 32'(s_q.p.paramLock);
                `VFC_OFS_MAXF:    s_d.rdata = 32'(s_q.p.maxRunFreq);
                `VFC_OFS_MIDF:    s_d.rdata = 32'(s_q.p.midCurveFreq);
                `VFC_OFS_MINF:    s_d.rdata = 32'(s_q.p.minCurveFreq);
                `VFC_OFS_TOPV:    s_d.rdata = 32'(s_q.p.topVoltage);
                `VFC_OFS_MIDV:    s_d.rdata = 32'(s_q.p.midCurveVoltage);
                `VFC_OFS_BOOSTV:  s_d.rdata = 32'(s_q.p.lowFreqBoostVoltage);
                `VFC_OFS_FLOOR:   s_d.rdata = 32'(s_q.p.freqFloor);
                `VFC_OFS_DRIVE:   s_d.rdata = 32'(s_q.p.driveMethodSelect);
                `VFC_OFS_RESTORE: s_d.rdata = 32'(s_q.p.restoreDefaultsCode);
                `VFC_OFS_ESTOP:   s_d.rdata = 32'(s_q.p.estopRampTime);
                `VFC_OFS_SETF:    s_d.rdata = 32'(s_q.p.setFreq);
                `VFC_OFS_REFF:    s_d.rdata = 32'(s_q.p.refFreq);
                `VFC_OFS_OUTF:    s_d.rdata = 32'(s_q.freq);
                `VFC_OFS_OUTV:    s_d.rdata = 32'(s_q.volt);
                `VFC_OFS_STATE:   s_d.rdata = {29'h0, s_q.driveOn, s_q.mode};
                default: begin
                    // pair times, otherwise unmapped reads zero
                    if (address >= `VFC_OFS_TIME0 &&
                        address <= `VFC_OFS_TIME7) begin
                        s_d.rdata = idx[0] ?
                            32'(s_q.p.decelTime[2'((idx - 6'h0A) >> 1)]) :
                            32'(s_q.p.accelTime[2'((idx - 6'h0A) >> 1)]);
                    end else begin
                        s_d.rdata = 32'h00000000;
                    end
                end
            endcase
        end
        // writes: lock and set frequency always, the rest when unlocked
        if (acc & write) begin
            if (address == `VFC_OFS_LOCK) begin
                s_d.p.paramLock = writedata[0];
            end else if (address == `VFC_OFS_SETF) begin
                if (wf <= s_q.p.maxRunFreq) begin
                    s_d.p.setFreq = wf;
                end
            end else if (!s_q.p.paramLock) begin
                case (address)
                    `VFC_OFS_MAXF: begin
                        if (wf >= `VFC_MAXF_MIN && wf <= `VFC_MAXF_MAX &&
                            wf > s_q.p.freqFloor) begin
                            s_d.p.maxRunFreq = wf;
                        end
                    end
                    `VFC_OFS_MIDF: begin
                        if (wf >= `VFC_MIDF_MIN && wf <= s_q.p.refFreq) begin
                            s_d.p.midCurveFreq = wf;
                        end
                    end
                    `VFC_OFS_MINF: begin
                        if (wf >= `VFC_MINF_MIN && wf <= `VFC_MINF_MAX) begin
                            s_d.p.minCurveFreq = wf;
                        end
                    end
                    `VFC_OFS_REFF: begin
                        if (wf >= `VFC_REFF_MIN && wf <= `VFC_MAXF_MAX) begin
                            s_d.p.refFreq = wf;
                        end
                    end
                    `VFC_OFS_TOPV: begin
                        if (wv >= `VFC_V_MIN && wv <= topLim) begin
                            s_d.p.topVoltage = wv;
                        end
                    end
                    `VFC_OFS_MIDV: begin
                        if (wv >= `VFC_V_MIN && wv <= `VFC_MIDV_MAX &&
                            wv <= s_q.p.topVoltage) begin
                            s_d.p.midCurveVoltage = wv;
                        end
                    end
                    `VFC_OFS_BOOSTV: begin
                        if (wv >= `VFC_V_MIN && wv <= `VFC_BOOSTV_MAX &&
                            wv <= s_q.p.topVoltage) begin
                            s_d.p.lowFreqBoostVoltage = wv;
                        end
                    end
                    `VFC_OFS_FLOOR: begin
                        if (wf < s_q.p.maxRunFreq) begin
                            s_d.p.freqFloor = wf;
                        end
                    end
                    `VFC_OFS_DRIVE: s_d.p.driveMethodSelect = writedata[0];
                    `VFC_OFS_ESTOP: begin
                        if (wt <= `VFC_TIME_MAX) begin
                            s_d.p.estopRampTime = wt;
                        end
                    end
                    `VFC_OFS_RESTORE: begin
                        if (writedata[7:0] == `VFC_RESTORE_GO) begin
                            s_d.p = defaults(grade220);
                        end else if (writedata[7:0] <= `VFC_RESTORE_MAX) begin
                            s_d.p.restoreDefaultsCode = writedata[7:0];
                        end
                    end
                    default: begin
                        // pair times; unmapped writes are dropped
                        if (address >= `VFC_OFS_TIME0 &&
                            address <= `VFC_OFS_TIME7 &&
                            wt >= `VFC_TIME_MIN && wt <= `VFC_TIME_MAX) begin
                            if (idx[0]) begin
                                s_d.p.decelTime[2'((idx - 6'h0A) >> 1)] = wt;
                            end else begin
                                s_d.p.accelTime[2'((idx - 6'h0A) >> 1)] = wt;
                            end
                        end
                    end
                endcase
            end
        end
        // mode sequencing: emergency stop from the terminal wins
        case (s_q.mode)
            VFC_IDLE: begin
                if (cmd.run | cmd.jog) begin
                    s_d.mode = VFC_RUN;
                end
            end
            VFC_RUN: begin
                if (!(cmd.run | cmd.jog) && s_q.freq == 17'h00000) begin
                    s_d.mode = VFC_IDLE;
                end
            end
            VFC_ESTOP: begin
                if (s_q.freq == 17'h00000 && !cmd.estop) begin
                    s_d.mode = VFC_IDLE;
                end
            end
            default: s_d.mode = VFC_IDLE;
        endcase
        if (cmd.estop) begin
            s_d.mode = VFC_ESTOP;
        end
        // ramp: one 0.01 Hz step each time the accumulator wraps
        if (s_q.mode == VFC_ESTOP && s_q.p.estopRampTime == 16'h0000) begin
            s_d.freq    = 17'h00000;
            s_d.acc     = 40'h0;
            s_d.driveOn = 1'b0;
        end else if (s_q.freq == target) begin
            s_d.acc     = 40'h0;
            s_d.driveOn = (s_q.mode != VFC_IDLE) && (s_q.freq != 17'h0);
        end else begin
            s_d.driveOn = 1'b1;
            if (accSum >= stepCycles) begin
                s_d.acc  = accSum - stepCycles;
                s_d.freq = (s_q.freq < target) ? s_q.freq + 17'h1 :
                                                 s_q.freq - 17'h1;
            end else begin
                s_d.acc = accSum;
            end
        end
        // clamp above floor while running, then below max always
        if (s_q.mode == VFC_RUN && (cmd.run | cmd.jog) &&
            s_d.freq < s_q.p.freqFloor) begin
            s_d.freq = s_q.p.freqFloor;
        end
        if (s_d.freq > s_q.p.maxRunFreq) begin
            s_d.freq = s_q.p.maxRunFreq;
        end
        // voltage from the six curve settings
        if (s_q.freq <= s_q.p.minCurveFreq) begin
            s_d.volt = s_q.p.lowFreqBoostVoltage;
        end else if (s_q.freq <= midF) begin
            s_d.volt = interp(s_q.freq, s_q.p.minCurveFreq, midF,
                              s_q.p.lowFreqBoostVoltage,
                              s_q.p.midCurveVoltage);
        end else if (s_q.freq <= s_q.p.refFreq) begin
            s_d.volt = interp(s_q.freq, midF, s_q.p.refFreq,
                              s_q.p.midCurveVoltage,
                              s_q.p.topVoltage);
        end else begin
            s_d.volt = s_q.p.topVoltage;
        end
        // synchronous reset to factory values
        if (reset) begin
            s_d         = '0;
            s_d.p       = defaults(grade220);
            s_d.mode    = VFC_IDLE;
            s_d.waitReq = 1'b1;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        s_q <= s_d;
    end

    // outputs straight from the state flops
    assign readdata    = s_q.rdata;
    assign waitrequest = s_q.waitReq;
    assign outFreq     = s_q.freq;
    assign outVoltage  = s_q.volt;
    assign driveOn     = s_q.driveOn;

    a_freq_ceiling: assert property (@(posedge core_clk) disable iff (reset)
        s_q.freq <= s_q.p.maxRunFreq || $changed(s_q.p.maxRunFreq))
        else $error("output frequency above maximum");
    a_lock_holds: assert property (@(posedge core_clk) disable iff (reset)
        acc && write && s_q.p.paramLock && address == `VFC_OFS_MAXF
        |=> $stable(s_q.p.maxRunFreq))
        else $error("locked parameter changed");
    a_restore_blocked: assert property (@(posedge core_clk) disable iff (reset)
        acc && write && s_q.p.paramLock && address == `VFC_OFS_RESTORE
        |=> $stable(s_q.p.accelTime) && $stable(s_q.p.topVoltage))
        else $error("restore acted while locked");
    a_restore_done: assert property (@(posedge core_clk) disable iff (reset)
        acc && write && !s_q.p.paramLock && address == `VFC_OFS_RESTORE &&
        writedata[7:0] == `VFC_RESTORE_GO
        |=> s_q.p.maxRunFreq == `VFC_MAXF_DEF &&
            s_q.p.accelTime[3] == `VFC_TIME_DEF)
        else $error("restore did not load defaults");
    a_coast_stop: assert property (@(posedge core_clk) disable iff (reset)
        s_q.mode == VFC_ESTOP && s_q.p.estopRampTime == 16'h0000
        |=> s_q.freq == 17'h0 && !s_q.driveOn)
        else $error("coast stop did not cut output");
    a_one_wait: assert property (@(posedge core_clk) disable iff (reset)
        req && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not after one wait cycle");
    a_jog_pair: assert property (@(posedge core_clk) disable iff (reset)
        cmd.jog |-> pair == 2'h3)
        else $error("jog not on pair four");
    a_default_pair: assert property (@(posedge core_clk) disable iff (reset)
        !cmd.jog && !cmd.multiSeg && cmd.termPair == 2'h0 |-> pair == 2'h0)
        else $error("default pair not pair one");
    a_top_hold: assert property (@(posedge core_clk) disable iff (reset)
        s_q.freq > s_q.p.refFreq && $stable(s_q.p.topVoltage)
        |=> s_q.volt == $past(s_q.p.topVoltage))
        else $error("voltage not held at top");
    a_floor_run: assert property (@(posedge core_clk) disable iff (reset)
        s_q.mode == VFC_RUN && cmd.run && !cmd.estop
        ##1 s_q.mode == VFC_RUN && cmd.run && $stable(s_q.p)
        |-> s_q.freq >= s_q.p.freqFloor)
        else $error("running below floor");

endmodule : vfc_curve_ramp

// File: testbench/vfc_term_model.sv
`timescale 1ns/1ps
// terminal and keypad model: requests become the command word
module vfc_term_model
    import vfc_pkg::*;
(
    // clock
    input  wire logic       core_clk,
    // operator requests
    input  wire logic       runReq,
    input  wire logic       jogReq,
    input  wire logic       stopReq,
    input  wire logic [1:0] pairReq,
    // command word toward the block
    output vfc_cmd_t        cmd
);
    vfc_cmd_t cmd_q = '0;  // terminal levels, quiet at power-up
    assign cmd = cmd_q;
    // terminals settle one edge after the operator acts
    always_ff @(posedge core_clk) begin
        cmd_q.run      <= runReq;
        cmd_q.jog      <= jogReq;
        cmd_q.estop    <= stopReq;
        cmd_q.multiSeg <= 1'b0;
        cmd_q.termPair <= pairReq;
        cmd_q.segPair  <= 2'h0;
    end
endmodule : vfc_term_model

// File: testbench/tb_vfc_curve_ramp.sv
`timescale 1ns/1ps
`include "vfc_regs.svh"
// self-checking bench for the curve and ramp block
module tb_vfc_curve_ramp
    import vfc_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic [7:0]  address  = 8'h00;
    logic        read     = 1'b0;
    logic        write    = 1'b0;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic        waitrequest, driveOn;
    logic [16:0] outFreq;
    logic [12:0] outVoltage;
    logic        runReq = 1'b0, jogReq = 1'b0, stopReq = 1'b0;
    logic [1:0]  pairReq = 2'h0;
    logic        grade220 = 1'b0;
    vfc_cmd_t    cmd;
    int          fails = 0, tests_run = 0;

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    vfc_term_model i_term (.core_clk(core_clk), .runReq(runReq),
        .jogReq(jogReq), .stopReq(stopReq), .pairReq(pairReq), .cmd(cmd));
    // short ramp time base keeps the run brief
    vfc_curve_ramp #(.TENTH_CYCLES(10)) i_dut (.core_clk(core_clk),
        .reset(reset), .grade220(grade220), .cmd(cmd), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .outFreq(outFreq), .outVoltage(outVoltage), .driveOn(driveOn));

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        address <= a; write <= w; read <= !w; writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rd = readdata;
        if (n >= 20) begin
            chk(n, 0);
            conclude();
        end
        read <= 1'b0; write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask : rdc

    // wait for a frequency, checking the cycle count lies in lo..hi
    task automatic waitF(input logic [16:0] e, input int lo, input int hi);
        int n;
        n = 0;
        while (outFreq !== e && n < hi) begin
            @(posedge core_clk);
            n++;
        end
        chk(outFreq, e);
        chk(n >= lo, 1'b1);
        if (outFreq !== e) conclude();
    endtask : waitF

    task automatic tDefaults;
        rdc(`VFC_OFS_MAXF, 32'h1388);
        rdc(`VFC_OFS_MIDF, 32'h01F4);
        rdc(`VFC_OFS_MINF, 32'h0032);
        rdc(`VFC_OFS_TOPV, 32'h0ED8);
        rdc(`VFC_OFS_BOOSTV, 32'h0064);
        rdc(`VFC_OFS_FLOOR, 32'h0000);
        rdc(`VFC_OFS_ESTOP, 32'h0000);
        bus(8'hFC, 1'b1, 32'h1);
        rdc(8'hFC, 32'h0);
    endtask : tDefaults

    task automatic tRefuse;
        bus(`VFC_OFS_MAXF, 1'b1, 32'h03E7);
        rdc(`VFC_OFS_MAXF, 32'h1388);
        bus(`VFC_OFS_MIDF, 1'b1, 32'h1389);
        rdc(`VFC_OFS_MIDF, 32'h01F4);
        bus(`VFC_OFS_TOPV, 1'b1, 32'h13ED);
        rdc(`VFC_OFS_TOPV, 32'h0ED8);
        bus(`VFC_OFS_MIDV, 1'b1, 32'h0ED9);
        rdc(`VFC_OFS_MIDV, 32'h00C8);
        bus(`VFC_OFS_FLOOR, 1'b1, 32'h1388);
        rdc(`VFC_OFS_FLOOR, 32'h0000);
    endtask : tRefuse

    task automatic tLock;
        bus(`VFC_OFS_MIDF, 1'b1, 32'h03E8);
        bus(`VFC_OFS_LOCK, 1'b1, 32'h1);
        bus(`VFC_OFS_MAXF, 1'b1, 32'h03E8);
        rdc(`VFC_OFS_MAXF, 32'h1388);
        bus(`VFC_OFS_RESTORE, 1'b1, 32'h08);
        rdc(`VFC_OFS_MIDF, 32'h03E8);
        bus(`VFC_OFS_LOCK, 1'b1, 32'h0);
        bus(`VFC_OFS_RESTORE, 1'b1, 32'h08);
        rdc(`VFC_OFS_MIDF, 32'h01F4);
    endtask : tLock

    // max 10 Hz, set point above it, pair one accel 20 s
    task automatic tRamp;
        bus(`VFC_OFS_MAXF, 1'b1, 32'h03E8);
        bus(`VFC_OFS_TIME0, 1'b1, 32'h00C8);
        bus(`VFC_OFS_FLOOR, 1'b1, 32'h0100);
        runReq <= 1'b1;
        waitF(17'h00100, 0, 6);
        waitF(17'h003E8, 1470, 1510);
        repeat (3) @(posedge core_clk);
        chk(outVoltage, 13'h0258);
        runReq <= 1'b0;
        waitF(17'h00000, 980, 1030);
        pairReq <= 2'h1;
        runReq <= 1'b1;
        waitF(17'h003E8, 730, 770);
        runReq <= 1'b0;
        waitF(17'h00000, 0, 1030);
        pairReq <= 2'h0;
        jogReq <= 1'b1;
        waitF(17'h003E8, 730, 770);
        stopReq <= 1'b1;
        waitF(17'h00000, 0, 8);
        chk(driveOn, 1'b0);
    endtask : tRamp

    // second reset with the 220 V strap, then a run above reference
    task automatic tGrade;
        runReq   <= 1'b0;
        jogReq   <= 1'b0;
        stopReq  <= 1'b0;
        grade220 <= 1'b1;
        reset    <= 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rdc(`VFC_OFS_TOPV, 32'h0898);
        bus(`VFC_OFS_TOPV, 1'b1, 32'h09F7);
        rdc(`VFC_OFS_TOPV, 32'h0898);
        bus(`VFC_OFS_TIME7, 1'b1, 32'h0123);
        rdc(`VFC_OFS_TIME7, 32'h0123);
        rdc(8'h34, 32'h0064);
        bus(`VFC_OFS_TIME0, 1'b1, 32'h01F4);
        bus(`VFC_OFS_REFF, 1'b1, 32'h03E8);
        bus(`VFC_OFS_SETF, 1'b1, 32'h07D0);
        runReq <= 1'b1;
        waitF(17'h007D0, 1990, 2020);
        repeat (2) @(posedge core_clk);
        chk(outVoltage, 13'h0898);
    endtask : tGrade

    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        tDefaults();
        tRefuse();
        tLock();
        tRamp();
        tGrade();
        conclude();
    end
endmodule : tb_vfc_curve_ramp
